// File: rtl/dsp_defs.svh
// constants for the dual serial port board
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
`define DSP_CLK_MHZ 100
`define DSP_WAIT_NS 500
`define DSP_WAIT_CYC ((`DSP_WAIT_NS * `DSP_CLK_MHZ + 999) / 1000)
`define DSP_FIFO_DEPTH 8
`define DSP_REG_CS 1'b0
`define DSP_REG_DATA 1'b1
`define DSP_CF_DIV 1:0
`define DSP_CF_FMT 4:2
`define DSP_CF_TXC 6:5
`define DSP_CF_RXIE 7
`define DSP_CF_RTS 6
`define DSP_DIV_1 2'h0
`define DSP_DIV_16 2'h1
`define DSP_DIV_64 2'h2
`define DSP_DIV_RST 2'h3
`define DSP_PH_1 6'h00
`define DSP_PH_16 6'h0f
`define DSP_PH_64 6'h3f
`define DSP_TXC_INT 2'h1
`define DSP_TXC_BRK 2'h3
`define DSP_FMT_8N2 3'h4
`define DSP_FMT_8N1 3'h5
`define DSP_NB7 4'h7
`define DSP_NB8 4'h8
`define DSP_CTRL_RST 8'h03
`endif

// File: rtl/dsp_pkg.sv
// types shared by the dual serial port board
package dsp_pkg;
  typedef struct packed {
    logic fe;
    logic pe;
    logic [7:0] data;
  } dsp_rx_word_t;
  typedef enum logic [1:0] {
    DSP_RX_IDLE = 2'h0,
    DSP_RX_START = 2'h1,
    DSP_RX_DATA = 2'h3
  } dsp_rx_state_t;
endpackage

// File: rtl/dsp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module dsp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
      end else begin
        if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && push && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// File: rtl/dsp_top.sv
// dual serial port board on an 8-bit processor i/o bus
// Operation
// - on io read the board drives register data while the data-in strobe is high.
// - on io write the board captures bus data while the write strobe is low.
// - address bits 7:2 compared to jumpers claim four consecutive addresses.
// - address bit 0 picks control/status or data, bit 1 picks the port.
// - control/status: write control, read status; data: write transmit, read receive.
// - each port holds its own 8-bit write-only control register.
// - control bits 1:0 pick divide by 1, 16, 64 or master reset.
// - control bits 4:2 pick data bits, parity and stop bits.
// - control bits 6:5 set request-to-send, transmit interrupt and break.
// - control bit 7 enables receive interrupts.
// - one or two independent ports, each with control, status and data.
// - every io read to the board drops ready for about 500 ns until acknowledged.
// - status bit 0 flags received data in the fifo; cleared when data reads empty the fifo, or by master reset.
// - status bit 1 high when transmit holding register is empty and clear-to-send is low.
// - status bit 7 high whenever that port's own interrupt request is asserted.
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_top import dsp_pkg::*; #(
  parameter int PORTS = 2,
  parameter int FIFO_DEPTH = `DSP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [5:0] jumper_base,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_out_en,
  input wire logic io_read_cycle_status,
  input wire logic io_write_cycle_status,
  input wire logic cpu_data_in_strobe,
  input wire logic cpu_write_strobe_n,
  output logic cpu_ready_line,
  input wire logic cpu_wait_ack,
  output logic irq_n,
  input wire logic [PORTS-1:0] baud_tick,
  input wire logic [PORTS-1:0] rxd,
  input wire logic [PORTS-1:0] cts_n,
  output logic [PORTS-1:0] txd,
  output logic [PORTS-1:0] rts_n
);
  localparam logic [7:0] WAIT_CYC = 8'(`DSP_WAIT_CYC);

  // address decode, qualified by io status and the read/write strobes
  wire hit = (addr[7:2] == jumper_base);
  wire io_rd = hit & io_read_cycle_status;
  wire sel_rd = io_rd & cpu_data_in_strobe;
  wire sel_wr = hit & io_write_cycle_status & ~cpu_write_strobe_n;
  wire reg_sel = addr[0];
  wire port_sel = addr[1];
  logic rd_q;
  logic wr_q;
  logic io_rd_q;
  wire rd_go = sel_rd & ~rd_q;
  wire wr_go = sel_wr & ~wr_q;
  wire wait_go = io_rd & ~io_rd_q;

  logic [7:0] status [PORTS];
  logic [7:0] rx_data [PORTS];
  logic [PORTS-1:0] irq;
  wire [7:0] rd_mux = (reg_sel == `DSP_REG_DATA) ? rx_data[port_sel] : status[port_sel];

  logic [7:0] wait_cnt;
  logic ack_seen;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      io_rd_q <= 1'b0;
      data_out <= 8'h00;
      data_out_en <= 1'b0;
      irq_n <= 1'b1;
    end else if (ce) begin
      rd_q <= sel_rd;
      wr_q <= sel_wr;
      io_rd_q <= io_rd;
      data_out_en <= sel_rd;
      if (rd_go) data_out <= rd_mux;
      irq_n <= ~(|irq);
    end
  end

  // wait state on every read to the board
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_ready_line <= 1'b1;
      wait_cnt <= 8'h00;
      ack_seen <= 1'b0;
    end else if (ce) begin
      if (wait_go) begin
        cpu_ready_line <= 1'b0;
        wait_cnt <= WAIT_CYC - 8'h01;
        ack_seen <= 1'b0;
      end else if (!cpu_ready_line) begin
        if (cpu_wait_ack) ack_seen <= 1'b1;
        if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
        else if (ack_seen || cpu_wait_ack) cpu_ready_line <= 1'b1;
      end
    end
  end

  for (genvar g = 0; g < PORTS; g++) begin : g_port
    logic [7:0] ctrl;
    logic [7:0] thr;
    logic thr_full;
    logic tx_busy;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [5:0] tx_ph;
    dsp_rx_state_t rx_st;
    logic [5:0] rx_ph;
    logic [3:0] rx_cnt;
    logic [9:0] rbits;
    logic ovr;
    logic push;
    dsp_rx_word_t push_word;
    dsp_rx_word_t head;
    logic fifo_ready;
    logic fifo_valid;
    logic [11:0] frame;
    logic [3:0] frame_len;

    wire me = (port_sel == 1'(g));
    wire wr_ctrl = wr_go & me & (reg_sel == `DSP_REG_CS);
    wire wr_data = wr_go & me & (reg_sel == `DSP_REG_DATA);
    wire pop = rd_go & me & (reg_sel == `DSP_REG_DATA);
    wire mrst = (ctrl[`DSP_CF_DIV] == `DSP_DIV_RST);
    wire [5:0] ph_max = (ctrl[`DSP_CF_DIV] == `DSP_DIV_64) ? `DSP_PH_64 :
                        (ctrl[`DSP_CF_DIV] == `DSP_DIV_16) ? `DSP_PH_16 : `DSP_PH_1;
    wire [5:0] ph_half = ph_max >> 1;
    wire [2:0] fmt = ctrl[`DSP_CF_FMT];
    wire [3:0] nb = fmt[2] ? `DSP_NB8 : `DSP_NB7;
    wire has_par = (fmt != `DSP_FMT_8N2) && (fmt != `DSP_FMT_8N1);
    wire stop2 = ~fmt[1] & ~(fmt == `DSP_FMT_8N1);
    wire odd = fmt[0];
    wire brk = (ctrl[`DSP_CF_TXC] == `DSP_TXC_BRK);
    wire [7:0] tx_d = fmt[2] ? thr : {1'b0, thr[6:0]};
    wire [3:0] rx_need = nb + 4'(has_par);
    wire [7:0] rx_d = fmt[2] ? rbits[7:0] : {1'b0, rbits[6:0]};
    wire tx_empty = ~thr_full & ~cts_n[g];

    // transmit frame, least significant bit first
    always_comb begin
      frame = 12'hfff;
      frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < nb) frame[i + 1] = tx_d[i];
      end
      if (has_par) frame[nb + 4'h1] = (^tx_d) ^ odd;
      frame_len = 4'h2 + nb + 4'(has_par) + 4'(stop2);
    end

    assign push_word = '{fe: ~rbits[rx_need], pe: has_par & (((^rx_d) ^ rbits[nb]) != odd), data: rx_d};

    dsp_fifo #(
      .WIDTH($bits(dsp_rx_word_t)),
      .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .flush(mrst),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_word),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(head)
    );

    assign irq[g] = ~mrst & ((ctrl[`DSP_CF_RXIE] & (fifo_valid | ovr)) |
                    ((ctrl[`DSP_CF_TXC] == `DSP_TXC_INT) & tx_empty));
    assign status[g] = {irq[g], head.pe, ovr, head.fe, cts_n[g], 1'b0, tx_empty, fifo_valid};
    assign rx_data[g] = head.data;

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        ctrl <= `DSP_CTRL_RST;
        thr <= 8'h00;
        thr_full <= 1'b0;
        tx_busy <= 1'b0;
        tx_sh <= 12'hfff;
        tx_left <= 4'h0;
        tx_ph <= 6'h00;
        txd[g] <= 1'b1;
        rts_n[g] <= 1'b1;
      end else if (ce) begin
        rts_n[g] <= ctrl[`DSP_CF_RTS];
        txd[g] <= brk ? 1'b0 : (tx_busy ? tx_sh[0] : 1'b1);
        if (mrst) begin
          thr_full <= 1'b0;
          tx_busy <= 1'b0;
          tx_ph <= 6'h00;
        end else if (!tx_busy) begin
          if (thr_full && !cts_n[g]) begin
            tx_sh <= frame;
            tx_left <= frame_len;
            tx_ph <= 6'h00;
            tx_busy <= 1'b1;
            thr_full <= 1'b0;
          end
        end else if (baud_tick[g]) begin
          if (tx_ph == ph_max) begin
            tx_ph <= 6'h00;
            tx_sh <= {1'b1, tx_sh[11:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) tx_busy <= 1'b0;
          end else begin
            tx_ph <= tx_ph + 6'h01;
          end
        end
        if (wr_data) begin
          thr <= data_in;
          thr_full <= 1'b1;
        end
        if (wr_ctrl) ctrl <= data_in;
      end
    end

    // receiver samples each bit in its middle, except in divide-by-1 mode where it samples once per tick
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        rx_st <= DSP_RX_IDLE;
        rx_ph <= 6'h00;
        rx_cnt <= 4'h0;
        rbits <= 10'h000;
        push <= 1'b0;
        ovr <= 1'b0;
      end else if (ce) begin
        push <= 1'b0;
        if (pop) ovr <= 1'b0;
        if (push && !fifo_ready) ovr <= 1'b1;
        if (mrst) begin
          rx_st <= DSP_RX_IDLE;
          ovr <= 1'b0;
        end else if (baud_tick[g]) begin
          case (rx_st)
            DSP_RX_IDLE: begin
              rx_ph <= 6'h00;
              rx_cnt <= 4'h0;
              if (!rxd[g]) rx_st <= (ph_max == `DSP_PH_1) ? DSP_RX_DATA : DSP_RX_START;
            end
            DSP_RX_START: begin
              if (rx_ph == ph_half) begin
                rx_ph <= 6'h00;
                rx_cnt <= 4'h0;
                rx_st <= rxd[g] ? DSP_RX_IDLE : DSP_RX_DATA;
              end else begin
                rx_ph <= rx_ph + 6'h01;
              end
            end
            DSP_RX_DATA: begin
              if (rx_ph == ph_max) begin
                rx_ph <= 6'h00;
                rx_cnt <= rx_cnt + 4'h1;
                rbits[rx_cnt] <= rxd[g];
                if (rx_cnt == rx_need) begin
                  push <= 1'b1;
                  rx_st <= DSP_RX_IDLE;
                end
              end else begin
                rx_ph <= rx_ph + 6'h01;
              end
            end
            default: rx_st <= DSP_RX_IDLE;
          endcase
        end
      end
    end
  end
endmodule

// File: test/dsp_chk.sv
// assertion checker for the dual serial port board
`timescale 1ns/1ps
module dsp_chk #(
  parameter int PORTS = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [5:0] jumper_base,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  input wire logic io_read_cycle_status,
  input wire logic io_write_cycle_status,
  input wire logic cpu_data_in_strobe,
  input wire logic cpu_write_strobe_n,
  input wire logic cpu_wait_ack,
  input wire logic cpu_ready_line,
  input wire logic data_out_en,
  input wire logic [PORTS-1:0] txd,
  input wire logic [PORTS-1:0] rts_n
);
  logic [6:0] low_cnt;
  logic ack_seen;
  wire hit = addr[7:2] == jumper_base;
  wire rd_hit = ce & hit & io_read_cycle_status & cpu_data_in_strobe;
  wire wr0 = ce & hit & io_write_cycle_status & !cpu_write_strobe_n & addr[1:0] == 2'h0;
  // length of the current wait and whether it was acknowledged
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 7'h00;
      ack_seen <= 1'b0;
    end else begin
      low_cnt <= cpu_ready_line ? 7'h00 : low_cnt + {6'h00, low_cnt != 7'h7f};
      ack_seen <= !cpu_ready_line & (ack_seen | cpu_wait_ack);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd_open; $rose(ce & hit & io_read_cycle_status); endsequence
  sequence s_ctl_wr; $rose(wr0); endsequence
  property p_wait_start; s_rd_open |=> !cpu_ready_line [*8]; endproperty
  a_wait_start: assert property (p_wait_start) else $error("ready not held low on read");
  property p_wait_len; $rose(cpu_ready_line) |-> low_cnt >= 7'h30; endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait state too short");
  property p_wait_ack; $rose(cpu_ready_line) |-> ack_seen; endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("wait ended without ack");
  property p_wr_nowait; $rose(ce & hit & io_write_cycle_status) |=> cpu_ready_line; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("wait state on write");
  property p_rd_drive; rd_hit |=> data_out_en; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  property p_rd_quiet; !rd_hit |=> !data_out_en; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("bus driven without hit");
  property p_rts; s_ctl_wr |-> ##3 rts_n[0] == $past(data_in[6], 3); endproperty
  a_rts: assert property (p_rts) else $error("rts does not follow control");
  property p_break; s_ctl_wr and data_in[6:5] == 2'h3 |-> ##3 !txd[0]; endproperty
  a_break: assert property (p_break) else $error("no break level");
  property p_mreset; s_ctl_wr and data_in[6:0] == 7'h03 |-> ##3 txd[0]; endproperty
  a_mreset: assert property (p_mreset) else $error("line not idle in reset");
endmodule

// File: test/dsp_cpu_model.sv
// behavioural processor running io input and output cycles
`timescale 1ns/1ps
module dsp_cpu_model (
  input wire logic ref_clk,
  output logic [7:0] addr,
  output logic [7:0] data_in,
  output logic io_read_cycle_status,
  output logic io_write_cycle_status,
  output logic cpu_data_in_strobe,
  output logic cpu_write_strobe_n,
  output logic cpu_wait_ack,
  input wire logic cpu_ready_line,
  input wire logic [7:0] data_out,
  output logic tmo
);
  initial begin
    addr = 8'hff;
    data_in = 8'h00;
    io_read_cycle_status = 1'b0;
    io_write_cycle_status = 1'b0;
    cpu_data_in_strobe = 1'b0;
    cpu_write_strobe_n = 1'b1;
    cpu_wait_ack = 1'b0;
    tmo = 1'b0;
  end
  // third machine cycle of an in or out instruction
  task automatic io_cyc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge ref_clk);
    addr <= a;
    data_in <= d;
    io_read_cycle_status <= !wr;
    io_write_cycle_status <= wr;
    @(posedge ref_clk);
    cpu_data_in_strobe <= !wr;
    cpu_write_strobe_n <= !wr;
    for (n = 0; n < 200; n++) begin
      @(posedge ref_clk);
      if (wr ? n == 1 : cpu_ready_line === 1'b1 && n > 2) break;
      cpu_wait_ack <= !wr && cpu_ready_line === 1'b0;
    end
    tmo <= n == 200;
    q = data_out;
    addr <= ~a;
    data_in <= ~d;
    io_read_cycle_status <= 1'b0;
    io_write_cycle_status <= 1'b0;
    cpu_data_in_strobe <= 1'b0;
    cpu_write_strobe_n <= 1'b1;
    cpu_wait_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// File: test/dsp_top_bench.sv
// self-checking bench for the dual serial port board
`timescale 1ns/1ps
module dsp_top_bench;
  localparam logic [5:0] BASE = 6'h11; // away from address 255
  logic ref_clk, rst, ce, data_out_en, irq_n, tmo;
  logic [5:0] jumper_base;
  logic [1:0] baud_tick, cts_n, txd, rts_n;
  logic [7:0] addr, data_in, data_out;
  logic io_read_cycle_status, io_write_cycle_status, cpu_data_in_strobe;
  logic cpu_write_strobe_n, cpu_ready_line, cpu_wait_ack;
  int num_errors = 0;
  int cmp_count = 0;
  dsp_top dut (.ref_clk, .rst, .ce, .jumper_base, .addr, .data_in, .data_out, .data_out_en,
    .io_read_cycle_status, .io_write_cycle_status, .cpu_data_in_strobe, .cpu_write_strobe_n,
    .cpu_ready_line, .cpu_wait_ack, .irq_n, .baud_tick, .rxd(txd), .cts_n, .txd, .rts_n);
  dsp_cpu_model cpu (.ref_clk, .addr, .data_in, .io_read_cycle_status, .io_write_cycle_status,
    .cpu_data_in_strobe, .cpu_write_strobe_n, .cpu_wait_ack, .cpu_ready_line, .data_out, .tmo);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic io(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    cpu.io_cyc(wr, {BASE, a}, d, q);
    if (tmo) begin
      num_errors++;
      finish_test();
    end
  endtask
  // handshake, break and decoding on port 0
  task automatic t_ctl;
    logic [7:0] q;
    io(1'b1, 2'h0, 8'h61, q);
    chk({6'h00, txd[0], rts_n[0]}, 8'h01);
    io(1'b1, 2'h0, 8'h21, q);
    chk({7'h00, irq_n}, 8'h00);
    ce <= 1'b0;
    io(1'b1, 2'h0, 8'h01, q);
    ce <= 1'b1;
    chk({7'h00, irq_n}, 8'h00);
    io(1'b0, 2'h0, 8'h00, q);
    chk(q & 8'h82, 8'h82);
    io(1'b1, 2'h0, 8'h01, q);
    chk({6'h00, irq_n, rts_n[0]}, 8'h02);
    cpu.io_cyc(1'b0, {~BASE, 2'h0}, 8'h00, q);
    cpu.io_cyc(1'b1, {~BASE, 2'h0}, 8'h61, q);
    chk({7'h00, rts_n[0]}, 8'h00);
    io(1'b1, 2'h0, 8'h03, q);
    $display("control test done");
  endtask
  // looped-back character in one format, ports alternate
  task automatic t_loop(input logic [2:0] fmt);
    logic [7:0] q, m;
    logic [1:0] p, dv;
    int n;
    p = {fmt[0], 1'b0};
    m = fmt[2] ? 8'hff : 8'h7f;
    dv = (fmt == 3'h5) ? 2'h0 : ((fmt == 3'h6) ? 2'h2 : 2'h1);
    io(1'b1, p, 8'h03, q);
    io(1'b1, p, {3'h4, fmt, dv}, q);
    io(1'b1, p | 2'h1, 8'ha5, q);
    for (n = 0; n < 40; n++) begin
      io(1'b0, p, 8'h00, q);
      if (q[0] === 1'b1) break;
    end
    if (n == 40) begin
      num_errors++;
      finish_test();
    end
    chk(q & 8'hd3, 8'h83);
    chk({7'h00, irq_n}, 8'h00);
    io(1'b0, p | 2'h1, 8'h00, q);
    chk(q & m, 8'ha5 & m);
    io(1'b0, p, 8'h00, q);
    chk(q & 8'h81, 8'h00);
    io(1'b1, p, 8'h03, q);
    $display("loop test format %0d done", fmt);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    jumper_base = BASE;
    baud_tick = 2'h3;
    cts_n = 2'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_ctl();
    for (int f = 0; f < 8; f++) begin
      t_loop(f[2:0]);
    end
    finish_test();
  end
endmodule
bind dsp_top dsp_chk #(.PORTS(PORTS)) u_chk (.ref_clk, .rst, .ce, .jumper_base, .addr, .data_in,
  .io_read_cycle_status, .io_write_cycle_status, .cpu_data_in_strobe, .cpu_write_strobe_n,
  .cpu_wait_ack, .cpu_ready_line, .data_out_en, .txd, .rts_n);
